// File: stosup_pkg.sv
// constants, types and register map of the torque-off supervisor
// How it works
// - card overtemperature pulls torque-off active and trip high; mode 6 latches PTC alarm.
// - relay modes accept torque-off without trip as a relay stop.
// - mode 7 restarts by itself once thermistor and relay stops clear.
// - modes 8 and 9 mix one latched alarm with one self-clearing warning.
// - mode values 4 to 9 are refused unless the card is present.
// - codes 68 and 71 report as warning or alarm; 72 only trip-locked alarm.
// - alarms 68, 71, 72 never clear without an explicit reset request.
// - bit 30 flags stops in both word pairs; bit 31 of alarm word two flags failure.
// - torque-off alarm clears on reset only after the input went inactive.
// - torque-off warning clears itself as soon as the input is inactive.
// - PTC alarm needs input inactive, trip inactive, then a reset request.
// - PTC warning clears itself once input and trip are both inactive.
// - modes 4 to 9 raise failure alarm on trip active with torque-off inactive.
// - modes 4 and 5 also raise failure on torque-off active without trip.
// - modes 2 and 3 ignore trip but still honour torque-off.
// - mode 0 does nothing; mode 1 latches alarm; mode 3 warns and resumes.
// - modes 5 and 7 hold off restart while trip indication stays active.
// - mode 8 PTC alarm, relay warning; mode 9 PTC warning, relay alarm.
package stosup_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ALARM1 = 8'h04;
    localparam logic [7:0] OFS_ALARM2 = 8'h08;
    localparam logic [7:0] OFS_WARN1 = 8'h0C;
    localparam logic [7:0] OFS_WARN2 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    // field positions
    localparam int BIT_STOP = 30;
    localparam int BIT_FAIL = 31;
    localparam int BIT_CTRL_RESET = 0;
    // mode values
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_STO_ALARM = 4'h1;
    localparam logic [3:0] MODE_STO_ALARM2 = 4'h2;
    localparam logic [3:0] MODE_STO_WARN = 4'h3;
    localparam logic [3:0] MODE_PTC_ALARM = 4'h4;
    localparam logic [3:0] MODE_PTC_WARN = 4'h5;
    localparam logic [3:0] MODE_RELAY_A = 4'h6;
    localparam logic [3:0] MODE_RELAY_W = 4'h7;
    localparam logic [3:0] MODE_RELAY_AW = 4'h8;
    localparam logic [3:0] MODE_RELAY_WA = 4'h9;
    localparam logic [3:0] MODE_CARD_MIN = 4'h4;
    // reset values
    localparam logic [3:0] MODE_RESET = 4'h1;
    localparam logic [4:0] PIN_SYNC_RESET = 5'h01;
    // synchronised pin levels, all active high
    typedef struct packed {
        logic resetKey;
        logic resetInput;
        logic cardPresent;
        logic tripActive;
        logic torqueOffActive;
    } stosup_pins_s;
    // supervisor flags
    typedef struct packed {
        logic dangerFail;
        logic ptcWarn;
        logic ptcAlarm;
        logic stoWarn;
        logic stoAlarm;
    } stosup_flags_s;
endpackage : stosup_pkg

// File: stosup_top.sv
// torque-off supervisor with APB register slave
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module stosup_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic torqueOffN,
    input wire logic cardTripIndication,
    input wire logic cardPresent,
    input wire logic resetInput,
    input wire logic resetKey,
    output logic coastMotor,
    output logic alarmActive,
    output logic warningActive
);
    logic [4:0] pinMeta_q;
    logic [4:0] pinSync_q;
    stosup_pkg::stosup_pins_s pins;
    logic resetReqPrev_q;
    logic resetReq;
    logic resetEdge;
    logic busReset;
    logic [3:0] mode_q;
    stosup_pkg::stosup_flags_s flags_q;
    logic sto;
    logic trip;
    logic stopPtc;
    logic stopRelay;
    logic mismatch;
    logic ptcIsAlarm;
    logic ptcIsWarn;
    logic relayIsAlarm;
    logic relayIsWarn;
    logic access;
    logic apbDone;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic coast_q;
    logic alarm_q;
    logic warn_q;
    logic [31:0] rdMux;
    logic rdHit;
    logic modeOk;

    // two-flop synchroniser for every pin; torque-off rests inactive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinMeta_q <= stosup_pkg::PIN_SYNC_RESET;
            pinSync_q <= stosup_pkg::PIN_SYNC_RESET;
        end else begin
            pinMeta_q <= {resetKey, resetInput, cardPresent,
                cardTripIndication, torqueOffN};
            pinSync_q <= pinMeta_q;
        end
    end

    // active-high view of the synchronised pins
    assign pins = stosup_pkg::stosup_pins_s'({pinSync_q[4:1], ~pinSync_q[0]});
    assign sto = pins.torqueOffActive;
    assign trip = pins.tripActive;

    // reset request from bus, input or key, taken on its rising edge
    assign access = psel && penable && !pready_q;
    assign apbDone = psel && penable && pready_q; // completion edge
    assign busReset = apbDone && pwrite && (paddr == stosup_pkg::OFS_CTRL)
        && pwdata[stosup_pkg::BIT_CTRL_RESET];
    assign resetReq = pins.resetInput || pins.resetKey;
    assign resetEdge = (resetReq && !resetReqPrev_q) || busReset;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resetReqPrev_q <= 1'b0;
        end else begin
            resetReqPrev_q <= resetReq;
        end
    end

    // mode decode: how each stop source answers
    always_comb begin
        ptcIsAlarm = 1'b0;
        ptcIsWarn = 1'b0;
        relayIsAlarm = 1'b0;
        relayIsWarn = 1'b0;
        unique case (mode_q)
            stosup_pkg::MODE_STO_ALARM,
            stosup_pkg::MODE_STO_ALARM2: relayIsAlarm = 1'b1;
            stosup_pkg::MODE_STO_WARN: relayIsWarn = 1'b1;
            stosup_pkg::MODE_PTC_ALARM: ptcIsAlarm = 1'b1;
            stosup_pkg::MODE_PTC_WARN: ptcIsWarn = 1'b1;
            stosup_pkg::MODE_RELAY_A: begin
                ptcIsAlarm = 1'b1;
                relayIsAlarm = 1'b1;
            end
            stosup_pkg::MODE_RELAY_W: begin
                ptcIsWarn = 1'b1;
                relayIsWarn = 1'b1;
            end
            stosup_pkg::MODE_RELAY_AW: begin
                ptcIsAlarm = 1'b1;
                relayIsWarn = 1'b1;
            end
            stosup_pkg::MODE_RELAY_WA: begin
                ptcIsWarn = 1'b1;
                relayIsAlarm = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // stop sources; modes 1 to 3 see any torque-off as a plain stop
    always_comb begin
        stopPtc = 1'b0;
        stopRelay = 1'b0;
        mismatch = 1'b0;
        if (mode_q >= stosup_pkg::MODE_CARD_MIN) begin
            stopPtc = sto && trip;
            stopRelay = sto && !trip && (relayIsAlarm || relayIsWarn);
            mismatch = (trip && !sto)
                || (sto && !trip && !relayIsAlarm && !relayIsWarn);
        end else if (mode_q != stosup_pkg::MODE_OFF) begin
            stopRelay = sto;
        end
    end

    // latched alarms; a new stop beats a reset in the same cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_q.stoAlarm <= 1'b0;
            flags_q.ptcAlarm <= 1'b0;
        end else begin
            if (stopRelay && relayIsAlarm) begin
                flags_q.stoAlarm <= 1'b1;
            end else if (resetEdge && !sto) begin
                flags_q.stoAlarm <= 1'b0;
            end
            if (stopPtc && ptcIsAlarm) begin
                flags_q.ptcAlarm <= 1'b1;
            end else if (resetEdge && !sto && !trip) begin
                flags_q.ptcAlarm <= 1'b0;
            end
        end
    end

    // self-clearing warnings
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_q.stoWarn <= 1'b0;
            flags_q.ptcWarn <= 1'b0;
        end else begin
            flags_q.stoWarn <= stopRelay && relayIsWarn;
            if (stopPtc && ptcIsWarn) begin
                flags_q.ptcWarn <= 1'b1;
            end else if (!sto && !trip) begin
                flags_q.ptcWarn <= 1'b0;
            end
        end
    end

    // trip-locked failure: reset clears only once the mismatch is gone
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_q.dangerFail <= 1'b0;
        end else if (mismatch) begin
            flags_q.dangerFail <= 1'b1;
        end else if (resetEdge) begin
            flags_q.dangerFail <= 1'b0;
        end
    end

    // coast while any stop, warning or alarm stands; failure forces it
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            coast_q <= 1'b0;
            alarm_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            coast_q <= flags_q.dangerFail || flags_q.stoAlarm
                || flags_q.ptcAlarm || flags_q.stoWarn
                || flags_q.ptcWarn || stopPtc || stopRelay;
            alarm_q <= flags_q.dangerFail || flags_q.stoAlarm
                || flags_q.ptcAlarm;
            warn_q <= flags_q.stoWarn || flags_q.ptcWarn;
        end
    end

    // mode write accepted only for legal values the card allows
    assign modeOk = (pwdata[3:0] <= stosup_pkg::MODE_RELAY_WA)
        && ((pwdata[3:0] < stosup_pkg::MODE_CARD_MIN) || pins.cardPresent);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_q <= stosup_pkg::MODE_RESET;
        end else if (apbDone && pwrite && (paddr == stosup_pkg::OFS_MODE)
            && modeOk) begin
            mode_q <= pwdata[3:0];
        end
    end

    // read mux with status word bits
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (paddr)
            stosup_pkg::OFS_MODE: rdMux[3:0] = mode_q;
            stosup_pkg::OFS_ALARM1: rdMux[stosup_pkg::BIT_STOP] =
                flags_q.stoAlarm;
            stosup_pkg::OFS_ALARM2: begin
                rdMux[stosup_pkg::BIT_STOP] = flags_q.ptcAlarm;
                rdMux[stosup_pkg::BIT_FAIL] = flags_q.dangerFail;
            end
            stosup_pkg::OFS_WARN1: rdMux[stosup_pkg::BIT_STOP] =
                flags_q.stoWarn;
            stosup_pkg::OFS_WARN2: rdMux[stosup_pkg::BIT_STOP] =
                flags_q.ptcWarn;
            stosup_pkg::OFS_STATUS: rdMux[3:0] = {pins.cardPresent, trip,
                sto, coast_q};
            stosup_pkg::OFS_CTRL: rdMux = 32'h0000_0000;
            default: rdHit = 1'b0;
        endcase
    end

    // APB answer: one wait state, error on unmapped or refused write
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access;
            pslverr_q <= access && (!rdHit || (pwrite
                && (paddr == stosup_pkg::OFS_MODE) && !modeOk));
            if (access && !pwrite) begin
                prdata_q <= rdHit ? rdMux : 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign coastMotor = coast_q;
    assign alarmActive = alarm_q;
    assign warningActive = warn_q;

    // failure flag follows a mismatch in the next cycle
    AST_FAIL_SET: assert property (@(posedge ref_clk)
        disable iff (reset) mismatch |=> flags_q.dangerFail)
        else $error("failure alarm not raised on mismatch");

    // failure is never cleared while the mismatch persists
    AST_FAIL_HOLD: assert property (@(posedge ref_clk)
        disable iff (reset)
        flags_q.dangerFail && mismatch |=> flags_q.dangerFail)
        else $error("failure alarm dropped during mismatch");

    // failure falls only through a reset edge with the mismatch gone
    AST_FAIL_NEEDS_RESET: assert property (@(posedge ref_clk)
        disable iff (reset)
        $fell(flags_q.dangerFail) |-> $past(resetEdge) && !$past(mismatch))
        else $error("failure alarm cleared without reset");

    // latched alarms fall only through a reset edge
    AST_ALARM_NEEDS_RESET: assert property (@(posedge ref_clk)
        disable iff (reset)
        $fell(flags_q.stoAlarm) |-> $past(resetEdge) && !$past(sto))
        else $error("torque-off alarm cleared without reset");

    AST_PTC_ALARM_RESET: assert property (@(posedge ref_clk)
        disable iff (reset) $fell(flags_q.ptcAlarm)
        |-> $past(resetEdge) && !$past(sto) && !$past(trip))
        else $error("PTC alarm cleared too early");

    // each stop latches its alarm or raises its warning one cycle later
    AST_STO_ALARM_SET: assert property (@(posedge ref_clk)
        disable iff (reset)
        stopRelay && relayIsAlarm |=> flags_q.stoAlarm)
        else $error("torque-off alarm not latched");

    AST_PTC_ALARM_SET: assert property (@(posedge ref_clk)
        disable iff (reset)
        stopPtc && ptcIsAlarm |=> flags_q.ptcAlarm)
        else $error("PTC alarm not latched");

    AST_PTC_WARN_SET: assert property (@(posedge ref_clk)
        disable iff (reset)
        stopPtc && ptcIsWarn |=> flags_q.ptcWarn)
        else $error("PTC warning not raised");

    // torque-off warning tracks the relay stop and drops with the input
    AST_STO_WARN_SET: assert property (@(posedge ref_clk)
        disable iff (reset)
        stopRelay && relayIsWarn |=> flags_q.stoWarn)
        else $error("torque-off warning not raised");

    AST_STO_WARN_CLR: assert property (@(posedge ref_clk)
        disable iff (reset) !sto |=> !flags_q.stoWarn)
        else $error("torque-off warning did not clear");

    // PTC warning clears itself within a cycle of both inputs inactive
    AST_PTC_WARN_AUTO: assert property (@(posedge ref_clk)
        disable iff (reset) flags_q.ptcWarn && !sto && !trip
        && !(stopPtc && ptcIsWarn) |=> !flags_q.ptcWarn)
        else $error("PTC warning did not clear");

    AST_PTC_WARN_HOLD: assert property (@(posedge ref_clk)
        disable iff (reset) flags_q.ptcWarn && trip |=> flags_q.ptcWarn)
        else $error("restart while trip still active");

    // relay modes take torque-off without trip as a relay stop
    AST_RELAY_STOP: assert property (@(posedge ref_clk)
        disable iff (reset)
        mode_q >= stosup_pkg::MODE_RELAY_A && sto && !trip
        |-> stopRelay && !stopPtc && !mismatch)
        else $error("relay stop not accepted");

    // plain torque-off modes never look at the trip indication
    AST_TRIP_IGNORED: assert property (@(posedge ref_clk)
        disable iff (reset)
        mode_q < stosup_pkg::MODE_CARD_MIN |-> !stopPtc && !mismatch)
        else $error("trip indication used in plain mode");

    // coast follows any standing stop two cycles later
    AST_COAST: assert property (@(posedge ref_clk)
        disable iff (reset)
        (stopPtc || stopRelay) && mode_q != stosup_pkg::MODE_OFF
        |=> ##1 coastMotor)
        else $error("coast missing after stop");

    // the alarm output follows the latched flags one cycle later
    AST_ALARM_OUT: assert property (@(posedge ref_clk)
        disable iff (reset) flags_q.dangerFail || flags_q.stoAlarm
        || flags_q.ptcAlarm |=> alarmActive)
        else $error("alarm output missing");

    // mode never takes a card value while the card is absent at write
    AST_MODE_GATE: assert property (@(posedge ref_clk)
        disable iff (reset)
        apbDone && pwrite && paddr == stosup_pkg::OFS_MODE
        && pwdata[3:0] >= stosup_pkg::MODE_CARD_MIN && !pins.cardPresent
        |=> mode_q == $past(mode_q))
        else $error("card mode accepted without card");

    AST_MODE_OFF: assert property (@(posedge ref_clk)
        disable iff (reset)
        mode_q == stosup_pkg::MODE_OFF |-> !stopPtc && !stopRelay
        && !mismatch)
        else $error("mode 0 reacted to input");

    AST_APB_READY: assert property (@(posedge ref_clk)
        disable iff (reset) psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule : stosup_top

// File: stosup_card_model.sv
// thermistor card and emergency-stop relay seen from the drive pins
`timescale 1ns/10ps
module stosup_card_model (
    input wire logic overTemp,
    input wire logic loopOpen,
    input wire logic eStop,
    input wire logic tripFault,
    output logic torqueOffN,
    output logic cardTripIndication
);
    // card stop or relay stop both pull the shared torque-off line low
    assign torqueOffN = !(overTemp || loopOpen || eStop);
    // trip only from the card's own stop; tripFault is an ordered card fault
    assign cardTripIndication = overTemp || loopOpen || tripFault;
endmodule : stosup_card_model

// File: safe_torque_off_supervisor_tb_top.sv
// self-checking bench for the torque-off supervisor
`timescale 1ns/10ps
module safe_torque_off_supervisor_tb_top;
    localparam logic [31:0] STOP = 32'h1 << stosup_pkg::BIT_STOP;
    localparam logic [31:0] FAIL = 32'h1 << stosup_pkg::BIT_FAIL;
    logic refClk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd, a1, p2, w2, r1, w1;
    logic torqueOffN, cardTripIndication, cardPresent, resetInput, resetKey;
    logic coastMotor, alarmActive, warningActive, ptcA, relA;
    logic overTemp, loopOpen, eStop, tripFault;
    logic [32:0] expQ[$];
    int mismatches, n_tests, resetSel, m;
    integer seed;

    stosup_top DUT (.ref_clk(refClk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .torqueOffN(torqueOffN), .cardTripIndication(cardTripIndication),
        .cardPresent(cardPresent), .resetInput(resetInput),
        .resetKey(resetKey), .coastMotor(coastMotor),
        .alarmActive(alarmActive), .warningActive(warningActive));
    stosup_card_model card (.overTemp(overTemp), .loopOpen(loopOpen),
        .eStop(eStop), .tripFault(tripFault), .torqueOffN(torqueOffN),
        .cardTripIndication(cardTripIndication));

    // free-running bench clock
    initial begin
        refClk = 1'h0;
        forever #4 refClk = ~refClk;
    end

    task final_report;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; the expected answer is queued for the monitor
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] exp);
        expQ.push_back(exp);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge refClk);
        penable <= 1'h1;
        do begin
            @(posedge refClk);
        end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge refClk);
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0, {1'h0, exp});
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'h1, a, d, {err, 32'h0});
    endtask : wr

    task words(input logic [31:0] x1, x2, y1, y2);
        rd(stosup_pkg::OFS_ALARM1, x1);
        rd(stosup_pkg::OFS_ALARM2, x2);
        rd(stosup_pkg::OFS_WARN1, y1);
        rd(stosup_pkg::OFS_WARN2, y2);
    endtask : words

    task outs(input logic c, input logic a, input logic w);
        check({30'h0, coastMotor, alarmActive, warningActive},
            {30'h0, c, a, w});
    endtask : outs

    // drive the far side, then let the synchroniser and flags land
    task pins(input logic ot, input logic lo, input logic es, input logic tf);
        overTemp <= ot;
        loopOpen <= lo;
        eStop <= es;
        tripFault <= tf;
        repeat (6) @(posedge refClk);
    endtask : pins

    // reset request, rotating over bus, digital input and panel key
    task doReset;
        case (resetSel % 3)
            0: wr(stosup_pkg::OFS_CTRL, 32'h1, 1'h0);
            1: resetInput <= 1'h1;
            default: resetKey <= 1'h1;
        endcase
        repeat (3) @(posedge refClk);
        resetInput <= 1'h0;
        resetKey <= 1'h0;
        resetSel++;
        repeat (6) @(posedge refClk);
    endtask : doReset

    task setMode(input logic [3:0] v);
        wr(stosup_pkg::OFS_MODE, {28'h0, v}, 1'h0);
        rd(stosup_pkg::OFS_MODE, {28'h0, v});
    endtask : setMode

    // monitor: each apb answer against the oldest queued expectation
    always @(posedge refClk) begin
        if (psel && penable && pready === 1'h1) begin
            if (expQ.size() > 0) begin
                check({pslverr, pwrite ? 32'h0 : prdata}, expQ.pop_front());
            end else begin
                mismatches++;
            end
        end
    end

    // watchdog well beyond the expected run length
    initial begin
        #(8 * 20000);
        mismatches++;
        final_report();
    end

    initial begin
        seed = 32'h37d9;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cardPresent, resetInput, resetKey} = 3'h0;
        {overTemp, loopOpen, eStop, tripFault} = 4'h0;
        reset = 1'h1;
        repeat (5) @(posedge refClk);
        reset <= 1'h0;
        @(posedge refClk);
        rd(stosup_pkg::OFS_MODE, 32'h1);
        words(32'h0, 32'h0, 32'h0, 32'h0);
        outs(1'h0, 1'h0, 1'h0);
        apb(1'h0, 8'h1C, 32'h0, {1'h1, 32'h0});
        rnd = $random(seed);
        wr(stosup_pkg::OFS_MODE, {28'h0, 4'h4 + rnd[3:0] % 4'h6}, 1'h1);
        wr(stosup_pkg::OFS_MODE, {28'h0, 4'hA + {2'h0, rnd[5:4]}}, 1'h1);
        rd(stosup_pkg::OFS_MODE, 32'h1);
        cardPresent <= 1'h1;
        // torque-off only modes
        for (m = 0; m < 4; m++) begin
            setMode(m[3:0]);
            a1 = (m == 1 || m == 2) ? STOP : 32'h0;
            pins(m == 2, 1'h0, m != 2, 1'h0);
            words(a1, 32'h0, m == 3 ? STOP : 32'h0, 32'h0);
            outs(m != 0, m == 1 || m == 2, m == 3);
            doReset();
            words(a1, 32'h0, m == 3 ? STOP : 32'h0, 32'h0);
            pins(1'h0, 1'h0, 1'h0, 1'h0);
            words(a1, 32'h0, 32'h0, 32'h0);
            doReset();
            words(32'h0, 32'h0, 32'h0, 32'h0);
            pins(1'h0, 1'h0, 1'h0, 1'h1);
            words(32'h0, 32'h0, 32'h0, 32'h0);
            outs(1'h0, 1'h0, 1'h0);
            pins(1'h0, 1'h0, 1'h0, 1'h0);
        end
        // thermistor card modes
        for (m = 4; m < 10; m++) begin
            setMode(m[3:0]);
            ptcA = (m % 2 == 0);
            relA = (m == 6 || m == 9);
            p2 = ptcA ? STOP : 32'h0;
            w2 = ptcA ? 32'h0 : STOP;
            r1 = relA ? STOP : 32'h0;
            w1 = relA ? 32'h0 : STOP;
            pins(!m[0], m[0], 1'h0, 1'h0);
            words(32'h0, p2, 32'h0, w2);
            outs(1'h1, ptcA, !ptcA);
            rd(stosup_pkg::OFS_STATUS, 32'h0000_000F);
            doReset();
            words(32'h0, p2, 32'h0, w2);
            pins(1'h0, 1'h0, 1'h0, 1'h0);
            words(32'h0, ptcA ? STOP : 32'h0, 32'h0, 32'h0);
            doReset();
            words(32'h0, 32'h0, 32'h0, 32'h0);
            pins(1'h0, 1'h0, 1'h1, 1'h0);
            if (m < 6) begin
                words(32'h0, FAIL, 32'h0, 32'h0);
            end else begin
                words(r1, 32'h0, w1, 32'h0);
            end
            pins(1'h0, 1'h0, 1'h0, 1'h0);
            doReset();
            pins(1'h0, 1'h0, 1'h0, 1'h1);
            doReset();
            words(32'h0, FAIL, 32'h0, 32'h0);
            outs(1'h1, 1'h1, 1'h0);
            pins(1'h0, 1'h0, 1'h0, 1'h0);
            doReset();
            words(32'h0, 32'h0, 32'h0, 32'h0);
        end
        final_report();
    end
endmodule : safe_torque_off_supervisor_tb_top
